// *** logic/cam_defines.vh ***
// constants for the clock alarm mask and readback block
// assumes a 13-bit serial port address space and byte-wide registers
`ifndef CAM_DEFINES_VH
`define CAM_DEFINES_VH

// -----------------------------------------------------------------
// register addresses on the serial control port
// -----------------------------------------------------------------
`define CAM_ADDR_W         13
`define CAM_A_LOOP1_MASK   13'h0070
`define CAM_A_GEN_MASK     13'h0071
`define CAM_A_IDENT_LOW    13'h0078
`define CAM_A_IDENT_MID    13'h0079
`define CAM_A_IDENT_HIGH   13'h007a
`define CAM_A_SUMMARY      13'h007b
`define CAM_A_LOOP1_RB     13'h007c
`define CAM_A_GEN_RB       13'h007d
`define CAM_A_LATCHED      13'h007e
`define CAM_A_SPARE        13'h007f

// -----------------------------------------------------------------
// reset values and fixed patterns
// -----------------------------------------------------------------
`define CAM_MASK_RST       8'h00
`define CAM_GEN_MASK_USED  8'h1f
`define CAM_ZERO_BYTE      8'h00
`define CAM_IDENT_DEFAULT  24'h5a3c96
`define CAM_PIN_RST        3'b010

// -----------------------------------------------------------------
// synchronised status vector layout
// -----------------------------------------------------------------
`define CAM_ST_W           15
`define CAM_ST_LOS_HI      3
`define CAM_ST_LOS_LO      0
`define CAM_ST_HOLD        4
`define CAM_ST_LOCK        5
`define CAM_ST_ACQ         6
`define CAM_ST_NEAR        7
`define CAM_ST_S_LOCK      8
`define CAM_ST_S_DIS       9
`define CAM_ST_S_NEAR      10
`define CAM_ST_S_ACQ       11
`define CAM_ST_SREF        12
`define CAM_ST_SYNC        13
`define CAM_ST_CLR         14

// -----------------------------------------------------------------
// serial pin vector and frame layout
// -----------------------------------------------------------------
`define CAM_PIN_SCLK       0
`define CAM_PIN_SEN_N      1
`define CAM_PIN_SDI        2
`define CAM_CNT_W          5
`define CAM_CNT_HDR_LAST   5'd15
`define CAM_CNT_DATA_FIRST 5'd16
`define CAM_CNT_LAST       5'd23
`define CAM_CNT_DONE       5'd24
`define CAM_CNT_ZERO       5'd0
`define CAM_CNT_ONE        5'd1
`define CAM_HDR_RW         15
`define CAM_BYTE_MSB       7

`endif

// *** logic/cam_sync3.v ***
// three-stage synchroniser with agreement filter, one lane per bit
// assumes inputs are asynchronous to clk and change slowly
`timescale 1ns/100ps
module cam_sync3 #(
    parameter                   WIDTH   = 1,
    parameter [WIDTH-1:0]       RST_VAL = {WIDTH{1'b0}}
) (
    input  wire                 clk,
    input  wire                 rst,
    input  wire [WIDTH-1:0]     d,
    output wire [WIDTH-1:0]     q
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
            reg s1_reg;
            reg s2_reg;
            reg s3_reg;
            reg q_reg;
            // stage one feeds stage two only; output moves on agreement
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    s1_reg <= RST_VAL[i];
                    s2_reg <= RST_VAL[i];
                    s3_reg <= RST_VAL[i];
                    q_reg  <= RST_VAL[i];
                end else begin
                    s1_reg <= d[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        q_reg <= s3_reg;
                    end
                end
            end
            assign q[i] = q_reg;
        end
    endgenerate

endmodule // cam_sync3

// *** logic/cam_alarm_top.v ***
// alarm masking, live status, latched records and product identifier
// assumes status pins come from analog loops asynchronous to SYS_CLK,
// and a host on the serial port clocking at most SYS_CLK/12
// frame: read flag, two spare bits, 13-bit address, one data byte
//
// What this block does
// - mask bits 7..4 gate near-lock, acquisition, lock, holdover onto alarm
// - mask bits 3..0 let each reference input loss add to alarm
// - second mask bits 4..0 gate sync, both-lock, phase, sync, loop2
// - summary readback bit 0 returns current alarm, upper bits zero
// - loop1 readback bits 7..4: near-lock, acquiring, locked, holdover
// - status bit 4 high when loop2 locked or off but unsynchronized
// - status bit 3 is 1 only when both loops are locked
// - status bit 2 is 1 when sysref output phase is stable
// - status bit 1 reads 1 until first synchronisation, then 0
// - status bit 0 shows clock synthesis loop near-lock
// - latched bits 6..4 stick on loop2 acq, loop1 acq, holdover
// - latched bits 3..0 stick on loss of each reference input
// - read-only 24-bit identifier over three bytes, low byte first
`timescale 1ns/100ps
`include "cam_defines.vh"

module cam_alarm_top #(
    parameter [23:0]            PRODUCT_IDENT = `CAM_IDENT_DEFAULT
) (
    input  wire                 SYS_CLK,
    input  wire                 RST,
    // serial control port
    input  wire                 SPI_SCLK,
    input  wire                 SPI_SEN_N,
    input  wire                 SPI_SDIO_IN,
    output wire                 SPI_SDIO_OUT,
    output wire                 SPI_SDIO_OE,
    // jitter cleaning loop status
    input  wire                 CLEAN_LOOP_NEAR_LOCK,
    input  wire                 CLEAN_LOOP_ACQUIRING,
    input  wire                 CLEAN_LOOP_LOCKED,
    input  wire                 CLEAN_LOOP_HOLDOVER,
    input  wire [3:0]           REFERENCE_INPUT_LOS,
    // clock synthesis loop status
    input  wire                 SYNTH_LOOP_LOCKED,
    input  wire                 SYNTH_LOOP_DISABLED,
    input  wire                 SYNTH_LOOP_NEAR_LOCK,
    input  wire                 SYNTH_LOOP_ACQUIRING,
    // sysref and synchronisation
    input  wire                 SYSREF_PHASE_VALID,
    input  wire                 SYNC_EVENT,
    input  wire                 CLEAR_EVENT,
    // combined alarm
    output wire                 ALARM
);

    // -------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------
    // combinational views, strobes and decode
    wire [`CAM_ST_W-1:0]        st_raw;
    wire [`CAM_ST_W-1:0]        st;
    wire [2:0]                  pin;
    wire                        sclk;
    wire                        sen_act;
    wire                        sdi;
    wire [15:0]                 hdr_next;
    wire [`CAM_ADDR_W-1:0]      rd_addr;
    wire [7:0]                  loop1_rb;
    wire [7:0]                  gen_rb;
    wire [7:0]                  latch_set;
    wire                        sync_rise;
    wire                        clr_rise;
    wire                        sclk_rise;
    wire                        sclk_fall;
    wire                        alarm_next;
    wire                        alarm_loop1;
    wire                        alarm_refs;
    wire                        alarm_gen;

    // state held from clock to clock, and the combinational latched_next and rd_byte
    reg  [7:0]                  loop1_mask_reg;
    reg  [7:0]                  gen_mask_reg;
    reg  [7:0]                  latched_reg;
    reg  [7:0]                  latched_next;
    reg                         never_synced_reg;
    reg                         alarm_reg;
    reg                         sync_q_reg;
    reg                         clr_q_reg;
    reg                         sclk_q_reg;
    reg  [`CAM_CNT_W-1:0]       cnt_reg;
    reg  [15:0]                 hdr_reg;
    reg  [6:0]                  wdat_reg;
    reg                         is_read_reg;
    reg  [`CAM_ADDR_W-1:0]      addr_reg;
    reg  [7:0]                  out_shift_reg;
    reg                         sdo_reg;
    reg                         oe_reg;
    reg  [7:0]                  rd_byte;

    // -------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------
    // a level must stand two clocks to pass, and the logic sees it four clocks after it changes
    // status pins gathered into one vector, same layout as loop1 mask
    assign st_raw = {CLEAR_EVENT, SYNC_EVENT, SYSREF_PHASE_VALID,
                     SYNTH_LOOP_ACQUIRING, SYNTH_LOOP_NEAR_LOCK,
                     SYNTH_LOOP_DISABLED, SYNTH_LOOP_LOCKED,
                     CLEAN_LOOP_NEAR_LOCK, CLEAN_LOOP_ACQUIRING,
                     CLEAN_LOOP_LOCKED, CLEAN_LOOP_HOLDOVER,
                     REFERENCE_INPUT_LOS};

    cam_sync3 #(
        .WIDTH   (`CAM_ST_W),
        .RST_VAL ({`CAM_ST_W{1'b0}})
    ) u_sync_status (
        .clk     (SYS_CLK),
        .rst     (RST),
        .d       (st_raw),
        .q       (st)
    );

    // enable idles high, so its lane resets high to avoid a false frame
    cam_sync3 #(
        .WIDTH   (3),
        .RST_VAL (`CAM_PIN_RST)
    ) u_sync_pins (
        .clk     (SYS_CLK),
        .rst     (RST),
        .d       ({SPI_SDIO_IN, SPI_SEN_N, SPI_SCLK}),
        .q       (pin)
    );

    assign sclk    = pin[`CAM_PIN_SCLK];
    assign sen_act = ~pin[`CAM_PIN_SEN_N];
    assign sdi     = pin[`CAM_PIN_SDI];

    // -------------------------------------------------------------
    // edge detection on filtered signals
    // -------------------------------------------------------------
    // all edges come from filtered copies, never from a first stage
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sync_q_reg <= 1'b0;
            clr_q_reg  <= 1'b0;
            sclk_q_reg <= 1'b0;
        end else begin
            sync_q_reg <= st[`CAM_ST_SYNC];
            clr_q_reg  <= st[`CAM_ST_CLR];
            sclk_q_reg <= sclk;
        end
    end

    // sync and clear use rising edges only, so a held level acts once; sclk has both
    assign sync_rise = st[`CAM_ST_SYNC] & ~sync_q_reg;
    assign clr_rise  = st[`CAM_ST_CLR] & ~clr_q_reg;
    assign sclk_rise = sclk & ~sclk_q_reg;
    assign sclk_fall = ~sclk & sclk_q_reg;

    // -------------------------------------------------------------
    // live readback views
    // -------------------------------------------------------------
    // loop1 view mirrors the synchronised vector bit for bit
    assign loop1_rb = st[`CAM_ST_NEAR:`CAM_ST_LOS_LO];

    // general view; bits 7..5 reserved and read zero
    assign gen_rb[7:5] = 3'b000;
    assign gen_rb[4]   = (st[`CAM_ST_S_LOCK] | st[`CAM_ST_S_DIS])
                         & never_synced_reg;
    assign gen_rb[3]   = st[`CAM_ST_LOCK] & st[`CAM_ST_S_LOCK];
    assign gen_rb[2]   = st[`CAM_ST_SREF];
    assign gen_rb[1]   = never_synced_reg;
    assign gen_rb[0]   = st[`CAM_ST_S_NEAR];

    // -------------------------------------------------------------
    // first-synchronisation record
    // -------------------------------------------------------------
    // set at reset, dropped for good by the first sync pulse seen
    // only a later reset brings the unsynchronised state back
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            never_synced_reg <= 1'b1;
        end else if (sync_rise) begin
            never_synced_reg <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // alarm combination
    // -------------------------------------------------------------
    // loop1 state sources, one mask bit each
    assign alarm_loop1 = |(loop1_rb[7:4] & loop1_mask_reg[7:4]);
    // reference input losses, one mask bit per input
    assign alarm_refs  = |(loop1_rb[3:0] & loop1_mask_reg[3:0]);
    // reserved bits 7..5 of the second mask are stored but never gate
    assign alarm_gen   = |(gen_rb & gen_mask_reg & `CAM_GEN_MASK_USED);
    // masked sources OR together; registered so the pin is glitch free
    assign alarm_next  = alarm_loop1 | alarm_refs | alarm_gen;

    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            alarm_reg <= 1'b0;
        end else begin
            alarm_reg <= alarm_next;
        end
    end

    // pin comes straight from the register, never from the gate tree
    assign ALARM = alarm_reg;

    // -------------------------------------------------------------
    // latched records
    // -------------------------------------------------------------
    // bit 7 has no source and always reads zero
    assign latch_set = {1'b0, st[`CAM_ST_S_ACQ], st[`CAM_ST_ACQ],
                        st[`CAM_ST_HOLD],
                        st[`CAM_ST_LOS_HI:`CAM_ST_LOS_LO]};

    // clear first, then set, so an event in the clear cycle survives
    always @* begin
        latched_next = latched_reg;
        if (clr_rise) begin
            latched_next = `CAM_ZERO_BYTE;
        end
        latched_next = latched_next | latch_set;
    end

    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            latched_reg <= `CAM_ZERO_BYTE;
        end else begin
            latched_reg <= latched_next;
        end
    end

    // -------------------------------------------------------------
    // read data selection
    // -------------------------------------------------------------
    // header as it stands after the current rising sclk
    assign hdr_next = {hdr_reg[14:0], sdi};
    assign rd_addr  = hdr_next[`CAM_ADDR_W-1:0];

    // unmapped and spare addresses answer zero
    // decoding ahead of the shift has the byte ready on the last rise
    always @* begin
        case (rd_addr)
            `CAM_A_LOOP1_MASK: rd_byte = loop1_mask_reg;
            `CAM_A_GEN_MASK:   rd_byte = gen_mask_reg;
            `CAM_A_IDENT_LOW:  rd_byte = PRODUCT_IDENT[7:0];
            `CAM_A_IDENT_MID:  rd_byte = PRODUCT_IDENT[15:8];
            `CAM_A_IDENT_HIGH: rd_byte = PRODUCT_IDENT[23:16];
            `CAM_A_SUMMARY:    rd_byte = {7'h00, alarm_reg};
            `CAM_A_LOOP1_RB:   rd_byte = loop1_rb;
            `CAM_A_GEN_RB:     rd_byte = gen_rb;
            `CAM_A_LATCHED:    rd_byte = latched_reg;
            default:           rd_byte = `CAM_ZERO_BYTE;
        endcase
    end

    // -------------------------------------------------------------
    // serial frame receiver
    // -------------------------------------------------------------
    // frame: 16 header bits (read flag first, address last 13 bits)
    // then 8 data bits, msb first; extra clocks in a frame are ignored
    // a frame cut short drops the count on deselect, so a half-shifted
    // header is never taken as an address
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            cnt_reg     <= `CAM_CNT_ZERO;
            hdr_reg     <= 16'h0000;
            wdat_reg    <= 7'h00;
            is_read_reg <= 1'b0;
            addr_reg    <= {`CAM_ADDR_W{1'b0}};
        end else if (!sen_act) begin
            cnt_reg     <= `CAM_CNT_ZERO;
            is_read_reg <= 1'b0;
        end else if (sclk_rise && cnt_reg != `CAM_CNT_DONE) begin
            cnt_reg <= cnt_reg + `CAM_CNT_ONE;
            if (cnt_reg <= `CAM_CNT_HDR_LAST) begin
                hdr_reg <= hdr_next;
            end else begin
                wdat_reg <= {wdat_reg[5:0], sdi};
            end
            if (cnt_reg == `CAM_CNT_HDR_LAST) begin
                is_read_reg <= hdr_next[`CAM_HDR_RW];
                addr_reg    <= rd_addr;
            end
        end
    end

    // -------------------------------------------------------------
    // mask register writes
    // -------------------------------------------------------------
    // commit on the last data bit; writes to read-only bytes dropped
    // reserved bits of the second mask are kept as written
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            loop1_mask_reg <= `CAM_MASK_RST;
            gen_mask_reg   <= `CAM_MASK_RST;
        end else if (sen_act && sclk_rise && !is_read_reg
                     && cnt_reg == `CAM_CNT_LAST) begin
            if (addr_reg == `CAM_A_LOOP1_MASK) begin
                loop1_mask_reg <= {wdat_reg, sdi};
            end
            if (addr_reg == `CAM_A_GEN_MASK) begin
                gen_mask_reg <= {wdat_reg, sdi};
            end
        end
    end

    // -------------------------------------------------------------
    // serial read driver
    // -------------------------------------------------------------
    // byte is captured at the end of the header so a read returns one
    // consistent snapshot; bits change on falling sclk for the host
    // limitation: a low sclk phase under six clocks can lose the data
    // edge, and the host then samples the previous bit
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            out_shift_reg <= `CAM_ZERO_BYTE;
            sdo_reg       <= 1'b0;
            oe_reg        <= 1'b0;
        end else if (!sen_act) begin
            oe_reg <= 1'b0;
        end else begin
            if (sclk_rise && cnt_reg == `CAM_CNT_HDR_LAST) begin
                out_shift_reg <= rd_byte;
            end
            if (sclk_fall && is_read_reg) begin
                if (cnt_reg >= `CAM_CNT_DATA_FIRST
                    && cnt_reg <= `CAM_CNT_LAST) begin
                    sdo_reg       <= out_shift_reg[`CAM_BYTE_MSB];
                    out_shift_reg <= {out_shift_reg[6:0], 1'b0};
                    oe_reg        <= 1'b1;
                end else begin
                    oe_reg <= 1'b0;
                end
            end
        end
    end

    // both port outputs come straight from flip-flops
    assign SPI_SDIO_OUT = sdo_reg;
    assign SPI_SDIO_OE  = oe_reg;

endmodule // cam_alarm_top

// *** bench/cam_alarm_properties.sv ***
// checker for serial readback and alarm pin timing of the alarm block
// assumes it is bound onto cam_alarm_top, one clock domain
`timescale 1ns/100ps
module cam_alarm_properties (
    input wire SYS_CLK,
    input wire RST,
    input wire SPI_SCLK,
    input wire SPI_SEN_N,
    input wire SPI_SDIO_OUT,
    input wire SPI_SDIO_OE,
    input wire ALARM
);
    // ------------------------------------------------
    // port timing
    // ------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // quiet after reset, read drive begins in a low sclk phase of a frame and ends with sclk low or after deselect
    a_reset_quiet: assert property (
        $fell(RST) |-> !ALARM && !SPI_SDIO_OE)
        else $error("outputs active after reset");
    a_oe_in_frame: assert property (
        $rose(SPI_SDIO_OE) |-> !SPI_SEN_N && !SPI_SCLK)
        else $error("read drive began outside low sclk");
    a_oe_holds_bit: assert property (
        $rose(SPI_SDIO_OE) |-> SPI_SDIO_OE[*6])
        else $error("read drive dropped early");
    a_oe_bounded: assert property (
        $rose(SPI_SDIO_OE) |-> ##[1:1000] !SPI_SDIO_OE)
        else $error("read drive never released");
    a_oe_release: assert property (
        $rose(SPI_SEN_N) |-> ##[1:8] !SPI_SDIO_OE)
        else $error("read drive kept after deselect");
    a_oe_fall_edge: assert property (
        $fell(SPI_SDIO_OE) |-> !SPI_SCLK || SPI_SEN_N)
        else $error("read drive released with sclk high");
    // data may move only while sclk is low, so the host samples it settled
    a_sdio_holds: assert property (
        SPI_SCLK[*4] |-> $stable(SPI_SDIO_OUT))
        else $error("read data moved in high sclk");
    a_sdio_moves_low: assert property (
        SPI_SDIO_OE && $changed(SPI_SDIO_OUT) |-> !SPI_SCLK)
        else $error("read data changed with sclk high");
endmodule // cam_alarm_properties

bind cam_alarm_top cam_alarm_properties cam_alarm_properties_inst (
    .SYS_CLK(SYS_CLK), .RST(RST), .SPI_SCLK(SPI_SCLK),
    .SPI_SEN_N(SPI_SEN_N), .SPI_SDIO_OUT(SPI_SDIO_OUT),
    .SPI_SDIO_OE(SPI_SDIO_OE), .ALARM(ALARM));

// *** bench/cam_host_model.sv ***
// host on the serial control port: 24-bit frames, read flag first
// assumes sys_clk runs free; sclk stands low between frames
`timescale 1ns/100ps
module cam_host_model (
    input  wire       sys_clk,
    input  wire       slow,
    input  wire       sdio_out,
    input  wire       sdio_oe,
    output reg        sclk,
    output reg        sen_n,
    output wire       sdio_line,
    output reg        rd_done,
    output reg  [7:0] rd_data
);
    reg host_en;
    reg host_val;
    // released line shows the inverted host bit, never a stale copy
    assign sdio_line = sdio_oe ? sdio_out : (host_en ? host_val : ~host_val);
    initial begin
        sclk = 1'b0;
        sen_n = 1'b1;
        host_en = 1'b1;
        host_val = 1'b0;
        rd_done = 1'b0;
        rd_data = 8'h00;
    end
    // ------------------------------------------------
    // one frame; phases of 7 or 11 clocks, above the 6 clock minimum
    // ------------------------------------------------
    task xfer(input rw, input [12:0] addr, input [7:0] wd);
        reg [23:0] f;
        reg [7:0]  rd;
        integer    i;
        integer    half;
        begin
            f = {rw, 2'b00, addr, wd};
            half = slow ? 11 : 7;
            rd = 8'h00;
            @(posedge sys_clk);
            sen_n <= 1'b0;
            for (i = 23; i >= 0; i = i - 1) begin
                host_en <= !(rw && i < 8);
                host_val <= f[i];
                repeat (half) @(posedge sys_clk);
                if (i < 8)
                    rd[i] = sdio_line;
                sclk <= 1'b1;
                repeat (half) @(posedge sys_clk);
                sclk <= 1'b0;
            end
            repeat (half) @(posedge sys_clk);
            sen_n <= 1'b1;
            host_en <= 1'b1;
            repeat (8) @(posedge sys_clk);
            rd_data <= rd;
            rd_done <= rw;
            @(posedge sys_clk);
            rd_done <= 1'b0;
        end
    endtask
endmodule // cam_host_model

// *** bench/clock_alarm_mask_readback_tb.sv ***
// self-checking bench for the alarm mask and readback block
// assumes the host model and the bound checker compile alongside
`timescale 1ns/100ps
`include "cam_defines.vh"
module clock_alarm_mask_readback_tb;
    localparam [23:0] IDENT = 24'h3ca517; // arbitrary identifier value
    reg         sys_clk, rst, sref, sync_ev, clr_ev, slow, ns, ea;
    reg  [7:0]  l1_in;   // near, acquiring, locked, holdover, los[3:0]
    reg  [3:0]  syn_in;  // locked, disabled, near lock, acquiring
    reg  [7:0]  m1, m2, lat, g, exp_q[$];
    reg  [12:0] a;
    reg  [31:0] r;
    integer     failures, checked, i;
    wire        sclk, sen_n, sdio_line, sdio_out, sdio_oe, alarm, rd_done;
    wire [7:0]  rd_data;
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    cam_alarm_top #(.PRODUCT_IDENT(IDENT)) cam_alarm_top_inst (
        .SYS_CLK(sys_clk), .RST(rst), .SPI_SCLK(sclk), .SPI_SEN_N(sen_n),
        .SPI_SDIO_IN(sdio_line), .SPI_SDIO_OUT(sdio_out),
        .SPI_SDIO_OE(sdio_oe),
        .CLEAN_LOOP_NEAR_LOCK(l1_in[7]), .CLEAN_LOOP_ACQUIRING(l1_in[6]),
        .CLEAN_LOOP_LOCKED(l1_in[5]), .CLEAN_LOOP_HOLDOVER(l1_in[4]),
        .REFERENCE_INPUT_LOS(l1_in[3:0]),
        .SYNTH_LOOP_LOCKED(syn_in[3]), .SYNTH_LOOP_DISABLED(syn_in[2]),
        .SYNTH_LOOP_NEAR_LOCK(syn_in[1]), .SYNTH_LOOP_ACQUIRING(syn_in[0]),
        .SYSREF_PHASE_VALID(sref), .SYNC_EVENT(sync_ev),
        .CLEAR_EVENT(clr_ev), .ALARM(alarm));
    cam_host_model cam_host_model_inst (.sys_clk(sys_clk), .slow(slow),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sclk(sclk), .sen_n(sen_n),
        .sdio_line(sdio_line), .rd_done(rd_done), .rd_data(rd_data));
    // ------------------------------------------------
    // compare, bus and closing tasks
    // ------------------------------------------------
    task check(input [7:0] seen, input [7:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [12:0] ad, input [7:0] d);
        cam_host_model_inst.xfer(1'b0, ad, d);
    endtask
    task rd(input [12:0] ad, input [7:0] e);
        begin
            exp_q.push_back(e);
            cam_host_model_inst.xfer(1'b1, ad, 8'h00);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d, mismatches %0d", checked, failures);
            if (failures == 0 && checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // each finished read is matched against the oldest note
    always @(posedge sys_clk) begin
        if (rd_done === 1'b1)
            check(rd_data, exp_q.pop_front());
    end
    // watchdog well above the expected run of about 37k to 54k clocks
    initial begin
        repeat (90000) @(posedge sys_clk);
        failures = failures + 1;
        finish_test;
    end
    initial begin
        {rst, sref, sync_ev, clr_ev, slow} = 5'b10000;
        {l1_in, syn_in} = 12'h000;
        failures = 0;
        checked = 0;
        r = $urandom(22795);
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        // reset values, identifier, unmapped and spare places read back
        for (a = 13'h70; a <= 13'h80; a = a + 13'h1)
            rd(a, a == `CAM_A_IDENT_LOW ? IDENT[7:0] :
                a == `CAM_A_IDENT_MID ? IDENT[15:8] :
                a == `CAM_A_IDENT_HIGH ? IDENT[23:16] :
                a == `CAM_A_GEN_RB ? 8'h02 : 8'h00);
        // writes to read-only places are refused
        wr(`CAM_A_IDENT_LOW, 8'hff);
        wr(`CAM_A_SUMMARY, 8'hff);
        rd(`CAM_A_IDENT_LOW, IDENT[7:0]);
        rd(`CAM_A_SUMMARY, 8'h00);
        ns = 1'b1;
        lat = 8'h00;
        for (i = 0; i < 10; i = i + 1) begin
            if (i == 4) begin
                // first synchronisation ends the never-synced state
                sync_ev <= 1'b1;
                repeat (6) @(posedge sys_clk);
                sync_ev <= 1'b0;
                ns = 1'b0;
            end
            if (i == 7) begin
                // clear with every source quiet empties the record
                {l1_in, syn_in} <= 12'h000;
                repeat (8) @(posedge sys_clk);
                clr_ev <= 1'b1;
                repeat (6) @(posedge sys_clk);
                clr_ev <= 1'b0;
                lat = 8'h00;
                rd(`CAM_A_LATCHED, 8'h00);
            end
            r = $urandom;
            m1 = $urandom;
            m2 = $urandom;
            @(posedge sys_clk);
            {slow, sref, syn_in, l1_in} <= r[13:0];
            lat = lat | {1'b0, r[8], r[6], r[4], r[3:0]};
            g = {3'b000, (r[11] | r[10]) & ns, r[5] & r[11], r[12], ns, r[9]};
            ea = |(m1 & r[7:0]) | |(m2[4:0] & g[4:0]);
            wr(`CAM_A_LOOP1_MASK, m1);
            wr(`CAM_A_GEN_MASK, m2);
            rd(`CAM_A_LOOP1_MASK, m1);
            rd(`CAM_A_GEN_MASK, m2);
            rd(`CAM_A_LOOP1_RB, r[7:0]);
            rd(`CAM_A_GEN_RB, g);
            rd(`CAM_A_LATCHED, lat);
            rd(`CAM_A_SUMMARY, {7'h00, ea});
            check({7'h00, alarm}, {7'h00, ea});
        end
        // second reset in mid-run brings masks and sync state back
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        g = {3'b000, r[11] | r[10], r[5] & r[11], r[12], 1'b1, r[9]};
        rd(`CAM_A_LOOP1_MASK, 8'h00);
        rd(`CAM_A_GEN_MASK, 8'h00);
        rd(`CAM_A_GEN_RB, g);
        rd(`CAM_A_SUMMARY, 8'h00);
        finish_test;
    end
endmodule // clock_alarm_mask_readback_tb
